/* src/cpu_flag_generation.sv */
// Purpose: Condition-flag generation for an 8-bit processor core, driven over Wishbone.
// Assumes: Classic single-cycle Wishbone master; one command executes per write.
// Notes:   Flags marked indeterminate are simply held, which keeps the logic small.
//
// The address map and the Wishbone interface to the registers were decided locally.
`timescale 1ns/1ns

module cpu_flag_generation (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  output logic      [7:0]  flags,
  output logic             irq_enable
);
  logic [7:0]  acc;
  logic [7:0]  operand;
  logic [15:0] mem_ptr;
  logic [15:0] wide_src;
  logic [15:0] byte_count;
  logic [7:0]  io_count;
  logic [15:0] result;
  logic        irq_live;
  logic        irq_saved;
  logic [31:0] read_word;
  logic [31:0] merged;
  logic        wr_fire;
  logic        exec;
  logic [4:0]  op;
  logic [2:0]  sel;
  logic [7:0]  next_acc;
  logic [7:0]  next_operand;
  logic [15:0] next_ptr;
  logic [7:0]  next_flags;
  logic [15:0] next_result;
  logic        acc_we;
  logic        operand_we;
  logic        ptr_we;
  logic [7:0]  add_a;
  logic [7:0]  add_b;
  logic        add_cin;
  logic        add_sub;
  logic [7:0]  add_sum;
  logic        add_carry;
  logic        add_half;
  logic        add_ovf;
  logic [15:0] wide_sum;
  logic        wide_carry;
  logic        wide_ovf;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] lanes);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (lanes[i]) begin
        m[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return m;
  endfunction

  // Writes take effect on the edge where the master sees ack.
  assign wr_fire = cyc_i && stb_i && ack_o && we_i;
  assign exec = wr_fire && (adr_i == flag_pkg::OFF_CMD) && sel_i[0];
  assign op = dat_i[4:0];
  assign sel = dat_i[flag_pkg::CMD_SEL_LSB +: 3];
  assign irq_enable = irq_live;
  // Lanes are merged into the addressed register's own read value, so unselected bytes hold.
  assign merged = merge(read_word, dat_i, sel_i);

  flag_adder #(.WIDTH(8), .HALF_BIT(4)) byte_adder (
    .a          (add_a),
    .b          (add_b),
    .carry_in   (add_cin),
    .subtract   (add_sub),
    .sum        (add_sum),
    .carry_out  (add_carry),
    .half_carry (add_half),
    .overflow   (add_ovf)
  );

  // The half-carry of the wide add is indeterminate, so its tap point is arbitrary.
  flag_adder #(.WIDTH(16), .HALF_BIT(12)) word_adder (
    .a          (mem_ptr),
    .b          (wide_src),
    .carry_in   (flags[flag_pkg::FLAG_CARRY]),
    .subtract   (op == flag_pkg::OP_SBC16),
    .sum        (wide_sum),
    .carry_out  (wide_carry),
    .half_carry (),
    .overflow   (wide_ovf)
  );

  always_comb begin
    add_a = acc;
    add_b = operand;
    add_cin = 1'b0;
    add_sub = 1'b0;
    if (op == flag_pkg::OP_ADC || op == flag_pkg::OP_SBC) begin
      add_cin = flags[flag_pkg::FLAG_CARRY];
    end
    if (op == flag_pkg::OP_SUB || op == flag_pkg::OP_SBC || op == flag_pkg::OP_CMP ||
        op == flag_pkg::OP_NEG || op == flag_pkg::OP_DEC) begin
      add_sub = 1'b1;
    end
    if (op == flag_pkg::OP_NEG) begin
      add_a = 8'h00;
      add_b = acc;
    end
    if (op == flag_pkg::OP_INC || op == flag_pkg::OP_DEC) begin
      add_a = operand;
      add_b = 8'h01;
    end
  end

  always_comb begin
    logic [7:0] v;
    logic       c;
    logic [7:0] fix;
    logic       bcd_c;
    v = 8'h00;
    c = 1'b0;
    fix = 8'h00;
    bcd_c = 1'b0;
    next_acc = acc;
    next_operand = operand;
    next_ptr = mem_ptr;
    next_flags = flags;
    next_result = result;
    acc_we = 1'b0;
    operand_we = 1'b0;
    ptr_we = 1'b0;
    case (op)
      flag_pkg::OP_ADD, flag_pkg::OP_ADC, flag_pkg::OP_SUB, flag_pkg::OP_SBC,
      flag_pkg::OP_CMP, flag_pkg::OP_NEG: begin
        v = add_sum;
        next_flags[flag_pkg::FLAG_SIGN] = v[7];
        next_flags[flag_pkg::FLAG_ZERO] = (v == 8'h00);
        next_flags[flag_pkg::FLAG_HALF] = add_half;
        next_flags[flag_pkg::FLAG_PV] = add_ovf;
        next_flags[flag_pkg::FLAG_SUB] = add_sub;
        next_flags[flag_pkg::FLAG_CARRY] = add_carry;
        next_result = {8'h00, v};
        acc_we = (op != flag_pkg::OP_CMP);
        next_acc = v;
      end
      flag_pkg::OP_AND, flag_pkg::OP_OR, flag_pkg::OP_XOR: begin
        if (op == flag_pkg::OP_AND) begin
          v = acc & operand;
        end else if (op == flag_pkg::OP_OR) begin
          v = acc | operand;
        end else begin
          v = acc ^ operand;
        end
        next_flags[flag_pkg::FLAG_SIGN] = v[7];
        next_flags[flag_pkg::FLAG_ZERO] = (v == 8'h00);
        next_flags[flag_pkg::FLAG_HALF] = (op == flag_pkg::OP_AND);
        next_flags[flag_pkg::FLAG_PV] = ~^v;
        next_flags[flag_pkg::FLAG_SUB] = 1'b0;
        next_flags[flag_pkg::FLAG_CARRY] = 1'b0;
        next_result = {8'h00, v};
        acc_we = 1'b1;
        next_acc = v;
      end
      flag_pkg::OP_INC, flag_pkg::OP_DEC: begin
        // Increment and decrement leave carry alone so multi-byte loops keep it.
        next_flags[flag_pkg::FLAG_SIGN] = add_sum[7];
        next_flags[flag_pkg::FLAG_ZERO] = (add_sum == 8'h00);
        next_flags[flag_pkg::FLAG_HALF] = add_half;
        next_flags[flag_pkg::FLAG_PV] = add_ovf;
        next_flags[flag_pkg::FLAG_SUB] = add_sub;
        next_result = {8'h00, add_sum};
        operand_we = 1'b1;
        next_operand = add_sum;
      end
      flag_pkg::OP_ADC16, flag_pkg::OP_SBC16: begin
        if (op == flag_pkg::OP_ADC16) begin
          next_flags[flag_pkg::FLAG_ZERO] = (wide_sum == 16'h0000);
        end
        next_flags[flag_pkg::FLAG_PV] = wide_ovf;
        next_flags[flag_pkg::FLAG_SUB] = (op == flag_pkg::OP_SBC16);
        next_flags[flag_pkg::FLAG_CARRY] = wide_carry;
        next_result = wide_sum;
        ptr_we = 1'b1;
        next_ptr = wide_sum;
      end
      flag_pkg::OP_SHIFT, flag_pkg::OP_ROT_A: begin
        if (op == flag_pkg::OP_SHIFT) begin
          v = operand;
        end else begin
          v = acc;
        end
        c = v[0];
        case (sel)
          flag_pkg::SH_RLC: begin
            c = v[7];
            v = {v[6:0], v[7]};
          end
          flag_pkg::SH_RRC: v = {v[0], v[7:1]};
          flag_pkg::SH_RL: begin
            c = v[7];
            v = {v[6:0], flags[flag_pkg::FLAG_CARRY]};
          end
          flag_pkg::SH_RR: v = {flags[flag_pkg::FLAG_CARRY], v[7:1]};
          flag_pkg::SH_SLA: begin
            c = v[7];
            v = {v[6:0], 1'b0};
          end
          flag_pkg::SH_SRA: v = {v[7], v[7:1]};
          default: v = {1'b0, v[7:1]};
        endcase
        if (op == flag_pkg::OP_SHIFT) begin
          next_flags[flag_pkg::FLAG_SIGN] = v[7];
          next_flags[flag_pkg::FLAG_ZERO] = (v == 8'h00);
          next_flags[flag_pkg::FLAG_PV] = ~^v;
          operand_we = 1'b1;
          next_operand = v;
        end else begin
          acc_we = 1'b1;
          next_acc = v;
        end
        next_flags[flag_pkg::FLAG_HALF] = 1'b0;
        next_flags[flag_pkg::FLAG_SUB] = 1'b0;
        next_flags[flag_pkg::FLAG_CARRY] = c;
        next_result = {8'h00, v};
      end
      flag_pkg::OP_DIG_L, flag_pkg::OP_DIG_R: begin
        if (op == flag_pkg::OP_DIG_L) begin
          v = {acc[7:4], operand[7:4]};
          next_operand = {operand[3:0], acc[3:0]};
        end else begin
          v = {acc[7:4], operand[3:0]};
          next_operand = {acc[3:0], operand[7:4]};
        end
        next_flags[flag_pkg::FLAG_SIGN] = v[7];
        next_flags[flag_pkg::FLAG_ZERO] = (v == 8'h00);
        next_flags[flag_pkg::FLAG_PV] = ~^v;
        next_flags[flag_pkg::FLAG_HALF] = 1'b0;
        next_flags[flag_pkg::FLAG_SUB] = 1'b0;
        next_result = {8'h00, v};
        acc_we = 1'b1;
        operand_we = 1'b1;
        next_acc = v;
      end
      flag_pkg::OP_BCD: begin
        // Subtract is told from add only by N, so N must survive until here.
        if (flags[flag_pkg::FLAG_HALF] ||
            (!flags[flag_pkg::FLAG_SUB] && acc[3:0] > flag_pkg::BCD_NIB_MAX)) begin
          fix = fix | flag_pkg::BCD_LO_FIX;
        end
        if (flags[flag_pkg::FLAG_CARRY] ||
            (!flags[flag_pkg::FLAG_SUB] && acc > flag_pkg::BCD_BYTE_MAX)) begin
          fix = fix | flag_pkg::BCD_HI_FIX;
          bcd_c = 1'b1;
        end
        if (flags[flag_pkg::FLAG_SUB]) begin
          v = acc - fix;
          next_flags[flag_pkg::FLAG_HALF] = flags[flag_pkg::FLAG_HALF] && (acc[3:0] < 4'h6);
        end else begin
          v = acc + fix;
          next_flags[flag_pkg::FLAG_HALF] = acc[3:0] > flag_pkg::BCD_NIB_MAX;
        end
        next_flags[flag_pkg::FLAG_SIGN] = v[7];
        next_flags[flag_pkg::FLAG_ZERO] = (v == 8'h00);
        next_flags[flag_pkg::FLAG_PV] = ~^v;
        next_flags[flag_pkg::FLAG_CARRY] = bcd_c;
        next_result = {8'h00, v};
        acc_we = 1'b1;
        next_acc = v;
      end
      flag_pkg::OP_BLK_IO: begin
        next_flags[flag_pkg::FLAG_ZERO] = (io_count != 8'h00);
        next_flags[flag_pkg::FLAG_SUB] = 1'b1;
      end
      flag_pkg::OP_BLK_MV: begin
        next_flags[flag_pkg::FLAG_HALF] = 1'b0;
        next_flags[flag_pkg::FLAG_SUB] = 1'b0;
        // The count register holds the value before this step's decrement, so one means done.
        next_flags[flag_pkg::FLAG_PV] = (byte_count != 16'h0001);
      end
      flag_pkg::OP_BLK_CP: begin
        next_flags[flag_pkg::FLAG_ZERO] = (acc == operand);
        next_flags[flag_pkg::FLAG_PV] = (byte_count != 16'h0001);
        next_flags[flag_pkg::FLAG_SUB] = 1'b1;
      end
      flag_pkg::OP_LD_SPC: begin
        next_flags[flag_pkg::FLAG_SIGN] = operand[7];
        next_flags[flag_pkg::FLAG_ZERO] = (operand == 8'h00);
        next_flags[flag_pkg::FLAG_PV] = irq_saved;
        next_flags[flag_pkg::FLAG_HALF] = 1'b0;
        next_flags[flag_pkg::FLAG_SUB] = 1'b0;
        next_result = {8'h00, operand};
        acc_we = 1'b1;
        next_acc = operand;
      end
      flag_pkg::OP_BIT: begin
        next_flags[flag_pkg::FLAG_ZERO] = operand[sel];
        next_flags[flag_pkg::FLAG_HALF] = 1'b1;
        next_flags[flag_pkg::FLAG_SUB] = 1'b0;
      end
      flag_pkg::OP_CPL: begin
        next_flags[flag_pkg::FLAG_HALF] = 1'b1;
        next_flags[flag_pkg::FLAG_SUB] = 1'b1;
        next_result = {8'h00, ~acc};
        acc_we = 1'b1;
        next_acc = ~acc;
      end
      flag_pkg::OP_SCF: begin
        next_flags[flag_pkg::FLAG_HALF] = 1'b0;
        next_flags[flag_pkg::FLAG_SUB] = 1'b0;
        next_flags[flag_pkg::FLAG_CARRY] = 1'b1;
      end
      flag_pkg::OP_CCF: begin
        next_flags[flag_pkg::FLAG_SUB] = 1'b0;
        next_flags[flag_pkg::FLAG_CARRY] = ~flags[flag_pkg::FLAG_CARRY];
      end
      default: begin
        next_flags = flags;
      end
    endcase
  end

  always_comb begin
    read_word = 32'h0000_0000;
    if (adr_i == flag_pkg::OFF_ACC) begin
      read_word = {24'h000000, acc};
    end else if (adr_i == flag_pkg::OFF_OPERAND) begin
      read_word = {24'h000000, operand};
    end else if (adr_i == flag_pkg::OFF_WIDE) begin
      read_word = {mem_ptr, wide_src};
    end else if (adr_i == flag_pkg::OFF_COUNTS) begin
      read_word = {8'h00, io_count, byte_count};
    end else if (adr_i == flag_pkg::OFF_FLAGS) begin
      read_word = {24'h000000, flags};
    end else if (adr_i == flag_pkg::OFF_RESULT) begin
      read_word = {16'h0000, result};
    end else if (adr_i == flag_pkg::OFF_IRQ) begin
      read_word = {30'h00000000, irq_saved, irq_live};
    end
  end

  // Ack rises one cycle after the request and falls the cycle after.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= cyc_i && stb_i && !ack_o;
      if (cyc_i && stb_i && !ack_o) begin
        dat_o <= read_word;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      acc <= flag_pkg::RST_BYTE;
      operand <= flag_pkg::RST_BYTE;
    end else if (exec) begin
      if (acc_we) begin
        acc <= next_acc;
      end
      if (operand_we) begin
        operand <= next_operand;
      end
    end else if (wr_fire && adr_i == flag_pkg::OFF_ACC) begin
      acc <= merged[7:0];
    end else if (wr_fire && adr_i == flag_pkg::OFF_OPERAND) begin
      operand <= merged[7:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      mem_ptr <= flag_pkg::RST_WORD;
      wide_src <= flag_pkg::RST_WORD;
      byte_count <= flag_pkg::RST_WORD;
      io_count <= flag_pkg::RST_BYTE;
    end else if (exec && ptr_we) begin
      mem_ptr <= next_ptr;
    end else if (wr_fire && adr_i == flag_pkg::OFF_WIDE) begin
      {mem_ptr, wide_src} <= merged;
    end else if (wr_fire && adr_i == flag_pkg::OFF_COUNTS) begin
      {io_count, byte_count} <= merged[23:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      flags <= flag_pkg::RST_FLAGS;
      result <= flag_pkg::RST_WORD;
    end else if (exec) begin
      flags <= next_flags;
      result <= next_result;
    end else if (wr_fire && adr_i == flag_pkg::OFF_FLAGS && sel_i[0]) begin
      flags <= dat_i[7:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      irq_live <= 1'b0;
      irq_saved <= 1'b0;
    end else if (exec && op == flag_pkg::OP_NMIRET) begin
      irq_live <= irq_saved;
    end else if (wr_fire && adr_i == flag_pkg::OFF_IRQ && sel_i[0]) begin
      irq_live <= dat_i[flag_pkg::IRQ_LIVE_BIT];
      irq_saved <= dat_i[flag_pkg::IRQ_SAVED_BIT];
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  a_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  a_add_flags: assert property (exec && op == flag_pkg::OP_ADD |=> !flags[1] &&
      flags[0] == ({1'b0, $past(acc)} + {1'b0, $past(operand)} > 9'h0ff))
    else $error("add carry or subtract flag wrong");
  a_sub_marks_n: assert property (exec &&
      (op == flag_pkg::OP_SUB || op == flag_pkg::OP_CMP)
      |=> flags[1] && flags[7] == (($past(acc) - $past(operand)) >> 7))
    else $error("subtract flags wrong");
  a_and_half: assert property (exec && op == flag_pkg::OP_AND |=> flags[4] && !flags[0])
    else $error("and half-carry or carry wrong");
  a_xor_parity: assert property (exec && op == flag_pkg::OP_XOR
      |=> flags[2] == ~^($past(acc) ^ $past(operand)))
    else $error("xor parity wrong");
  a_or_zero: assert property (exec && op == flag_pkg::OP_OR
      |=> flags[6] == (($past(acc) | $past(operand)) == 8'h00))
    else $error("or zero flag wrong");
  a_io_zero: assert property (exec && op == flag_pkg::OP_BLK_IO
      |=> flags[6] == ($past(io_count) != 8'h00) && flags[1] && $stable(flags[0]))
    else $error("block io flags wrong");
  a_move_count: assert property (exec && op == flag_pkg::OP_BLK_MV
      |=> flags[2] == ($past(byte_count) != 16'h0001) && !flags[4] && !flags[1])
    else $error("block move flags wrong");
  a_nmi_copy: assert property (exec && op == flag_pkg::OP_NMIRET
      |=> irq_enable == $past(irq_saved))
    else $error("enable not restored");
  a_flags_hold: assert property (!wr_fire |=> $stable(flags))
    else $error("flags changed without a write");

  c_add_exec: cover property (exec && op == flag_pkg::OP_ADD ##1 flags[0]);
  c_bcd_after_sub: cover property (exec && op == flag_pkg::OP_SUB
      ##[1:20] exec && op == flag_pkg::OP_BCD);
  c_nmi_return: cover property (exec && op == flag_pkg::OP_NMIRET ##1 irq_enable);
endmodule

/* src/flag_pkg.sv */
// Purpose: Shared constants for the condition-flag generation block.
// Assumes: Byte addressed classic Wishbone with 32-bit data words.
// Notes:   Command codes select the instruction class whose flags are produced.
package flag_pkg;

  // Flag byte layout.
  localparam int FLAG_SIGN  = 7;
  localparam int FLAG_ZERO  = 6;
  localparam int FLAG_HALF  = 4;
  localparam int FLAG_PV    = 2;
  localparam int FLAG_SUB   = 1;
  localparam int FLAG_CARRY = 0;

  // Register byte offsets.
  localparam logic [7:0] OFF_ACC     = 8'h00;
  localparam logic [7:0] OFF_OPERAND = 8'h04;
  localparam logic [7:0] OFF_WIDE    = 8'h08;
  localparam logic [7:0] OFF_COUNTS  = 8'h0c;
  localparam logic [7:0] OFF_CMD     = 8'h10;
  localparam logic [7:0] OFF_FLAGS   = 8'h14;
  localparam logic [7:0] OFF_RESULT  = 8'h18;
  localparam logic [7:0] OFF_IRQ     = 8'h1c;

  // Field positions.
  localparam int CMD_SEL_LSB    = 5;
  localparam int WIDE_PTR_LSB   = 16;
  localparam int COUNT_IO_LSB   = 16;
  localparam int IRQ_LIVE_BIT   = 0;
  localparam int IRQ_SAVED_BIT  = 1;

  // Values after reset.
  localparam logic [7:0]  RST_BYTE  = 8'h00;
  localparam logic [15:0] RST_WORD  = 16'h0000;
  localparam logic [7:0]  RST_FLAGS = 8'h00;

  // Command codes.
  localparam logic [4:0] OP_ADD    = 5'h00;
  localparam logic [4:0] OP_ADC    = 5'h01;
  localparam logic [4:0] OP_SUB    = 5'h02;
  localparam logic [4:0] OP_SBC    = 5'h03;
  localparam logic [4:0] OP_CMP    = 5'h04;
  localparam logic [4:0] OP_NEG    = 5'h05;
  localparam logic [4:0] OP_AND    = 5'h06;
  localparam logic [4:0] OP_OR     = 5'h07;
  localparam logic [4:0] OP_XOR    = 5'h08;
  localparam logic [4:0] OP_INC    = 5'h09;
  localparam logic [4:0] OP_DEC    = 5'h0a;
  localparam logic [4:0] OP_ADC16  = 5'h0b;
  localparam logic [4:0] OP_SBC16  = 5'h0c;
  localparam logic [4:0] OP_SHIFT  = 5'h0d;
  localparam logic [4:0] OP_DIG_L  = 5'h0e;
  localparam logic [4:0] OP_DIG_R  = 5'h0f;
  localparam logic [4:0] OP_BCD    = 5'h10;
  localparam logic [4:0] OP_BLK_IO = 5'h11;
  localparam logic [4:0] OP_BLK_MV = 5'h12;
  localparam logic [4:0] OP_BLK_CP = 5'h13;
  localparam logic [4:0] OP_LD_SPC = 5'h14;
  localparam logic [4:0] OP_BIT    = 5'h15;
  localparam logic [4:0] OP_NMIRET = 5'h16;
  localparam logic [4:0] OP_CPL    = 5'h17;
  localparam logic [4:0] OP_SCF    = 5'h18;
  localparam logic [4:0] OP_CCF    = 5'h19;
  localparam logic [4:0] OP_ROT_A  = 5'h1a;

  // Shift selector codes for OP_SHIFT and OP_ROT_A.
  localparam logic [2:0] SH_RLC = 3'h0;
  localparam logic [2:0] SH_RRC = 3'h1;
  localparam logic [2:0] SH_RL  = 3'h2;
  localparam logic [2:0] SH_RR  = 3'h3;
  localparam logic [2:0] SH_SLA = 3'h4;
  localparam logic [2:0] SH_SRA = 3'h5;
  localparam logic [2:0] SH_SRL = 3'h6;

  // Decimal adjust thresholds and corrections.
  localparam logic [3:0] BCD_NIB_MAX = 4'h9;
  localparam logic [7:0] BCD_BYTE_MAX = 8'h99;
  localparam logic [7:0] BCD_LO_FIX  = 8'h06;
  localparam logic [7:0] BCD_HI_FIX  = 8'h60;

endpackage

/* src/flag_adder.sv */
// Purpose: Adder and subtractor that also yields carry, half-carry and overflow.
// Assumes: For subtraction carry_in is a borrow and carry_out is a borrow.
// Notes:   Half-carry is taken at HALF_BIT from the operand and sum bits.
`timescale 1ns/1ns
module flag_adder #(
  parameter int WIDTH    = 8,
  parameter int HALF_BIT = 4
) (
  input  wire logic [WIDTH-1:0] a,
  input  wire logic [WIDTH-1:0] b,
  input  wire logic             carry_in,
  input  wire logic             subtract,
  output logic      [WIDTH-1:0] sum,
  output logic                  carry_out,
  output logic                  half_carry,
  output logic                  overflow
);
  logic [WIDTH-1:0] b_eff;
  logic [WIDTH:0]   total;

  assign b_eff = subtract ? ~b : b;
  // Subtraction adds the inverted operand with an inverted borrow.
  assign total = {1'b0, a} + {1'b0, b_eff} + {{WIDTH{1'b0}}, carry_in ^ subtract};
  assign sum = total[WIDTH-1:0];
  assign carry_out = total[WIDTH] ^ subtract;
  assign half_carry = a[HALF_BIT] ^ b[HALF_BIT] ^ sum[HALF_BIT];
  assign overflow = (a[WIDTH-1] == b_eff[WIDTH-1]) && (sum[WIDTH-1] != a[WIDTH-1]);
endmodule

/* verification/test_cpu_flag_generation.sv */
// Purpose: Self-checking bench for the flag generation block over Wishbone.
// Assumes: Flags are read back both on the port and through the bus.
// Notes:   Indeterminate and unused flag bits are masked, except in the all-bit check right after reset.
`timescale 1ns/1ns
module test_cpu_flag_generation;
  logic        sys_clk, sys_rst, cyc, stb, we, ack_o, irq_enable;
  logic [7:0]  adr, flags;
  logic [31:0] dat, dat_o, q;
  int          error_cnt, tests_run;

  cpu_flag_generation cpu_flag_generation_inst (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(4'hf), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
    .flags(flags), .irq_enable(irq_enable));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
    tests_run++;
    if ((got & m) !== (exp & m)) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got & m, exp & m);
    end
  endtask

  // Read data and ack are taken at the edge itself, before that edge's updates land.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int   n;
    logic ok;
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (ack_o !== 1'b1 && n < 16);
    q = dat_o;
    ok = (ack_o === 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge sys_clk);
    if (!ok) begin
      error_cnt++;
      end_sim();
    end
  endtask

  task automatic t(input logic [7:0] a, s, input logic [31:0] w, c,
                   input logic [7:0] p, op, e, m);
    wb(1'b1, flag_pkg::OFF_ACC, {24'h0, a});
    wb(1'b1, flag_pkg::OFF_OPERAND, {24'h0, s});
    wb(1'b1, flag_pkg::OFF_WIDE, w);
    wb(1'b1, flag_pkg::OFF_COUNTS, c);
    wb(1'b1, flag_pkg::OFF_FLAGS, {24'h0, p});
    wb(1'b1, flag_pkg::OFF_CMD, {24'h0, op});
    wb(1'b0, flag_pkg::OFF_FLAGS, 32'h0);
    chk(q, {24'h0, e}, {24'h0, m});
    chk({24'h0, flags}, {24'h0, e}, {24'h0, m});
    $display("test op %h done", op);
  endtask

  // The adjust must see the half-carry and subtract flags left by the previous op.
  task automatic bcd(input logic [7:0] a, s, op, ea, ef);
    t(a, s, 32'h0, 32'h0, 8'h00, op, {6'h0, op != flag_pkg::OP_ADD, 1'b0}, 8'h03);
    wb(1'b1, flag_pkg::OFF_CMD, {27'h0, flag_pkg::OP_BCD});
    wb(1'b0, flag_pkg::OFF_ACC, 32'h0);
    chk(q, {24'h0, ea}, 32'h000000ff);
    chk({24'h0, flags}, {24'h0, ef}, 32'h00000007);
  endtask

  initial begin
    sys_rst = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    dat = 32'h0;
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    chk({23'h0, irq_enable, flags}, 32'h0, 32'h000001ff);
    wb(1'b0, 8'h20, 32'h0);
    chk(q, 32'h0, 32'hffffffff);
    t(8'h7f, 8'h01, 32'h0, 32'h0, 8'h02, flag_pkg::OP_ADD, 8'h94, 8'hd7);
    t(8'hff, 8'h00, 32'h0, 32'h0, 8'h01, flag_pkg::OP_ADC, 8'h51, 8'hd7);
    t(8'h00, 8'h01, 32'h0, 32'h0, 8'h00, flag_pkg::OP_SUB, 8'h93, 8'hd7);
    t(8'h80, 8'h01, 32'h0, 32'h0, 8'h00, flag_pkg::OP_CMP, 8'h16, 8'hd7);
    t(8'h80, 8'h00, 32'h0, 32'h0, 8'h00, flag_pkg::OP_NEG, 8'h87, 8'hd7);
    t(8'hf0, 8'h3c, 32'h0, 32'h0, 8'h03, flag_pkg::OP_AND, 8'h14, 8'hd7);
    t(8'h01, 8'h02, 32'h0, 32'h0, 8'h13, flag_pkg::OP_OR, 8'h04, 8'hd7);
    t(8'h80, 8'h00, 32'h0, 32'h0, 8'h17, flag_pkg::OP_XOR, 8'h80, 8'hd7);
    t(8'h00, 8'h81, 32'h0, 32'h0, 8'h12, {3'h4, flag_pkg::OP_SHIFT}, 8'h01, 8'hd7);
    t(8'h00, 8'h01, 32'h0, 32'h0, 8'h00, {3'h6, flag_pkg::OP_SHIFT}, 8'h45, 8'hd7);
    t(8'h12, 8'h34, 32'h0, 32'h0, 8'h13, flag_pkg::OP_DIG_L, 8'h01, 8'hd7);
    t(8'h00, 8'h00, 32'h7fff0001, 32'h0, 8'h42, flag_pkg::OP_ADC16, 8'h04, 8'h47);
    t(8'h00, 8'h00, 32'h00000001, 32'h0, 8'h00, flag_pkg::OP_SBC16, 8'h03, 8'h07);
    t(8'h00, 8'h00, 32'h0, 32'h2, 8'h17, flag_pkg::OP_BLK_MV, 8'h05, 8'h17);
    t(8'h00, 8'h00, 32'h0, 32'h1, 8'h17, flag_pkg::OP_BLK_MV, 8'h01, 8'h17);
    t(8'h55, 8'h55, 32'h0, 32'h2, 8'h01, flag_pkg::OP_BLK_CP, 8'h47, 8'h47);
    t(8'h00, 8'h00, 32'h0, 32'h20000, 8'h01, flag_pkg::OP_BLK_IO, 8'h43, 8'h43);
    wb(1'b1, flag_pkg::OFF_IRQ, 32'h2);
    t(8'h00, 8'h00, 32'h0, 32'h0, 8'h13, flag_pkg::OP_LD_SPC, 8'h45, 8'hd7);
    t(8'h00, 8'h08, 32'h0, 32'h0, 8'h03, {3'h3, flag_pkg::OP_BIT}, 8'h51, 8'h53);
    t(8'h00, 8'h00, 32'h0, 32'h0, 8'hd6, flag_pkg::OP_SCF, 8'hc5, 8'hd7);
    t(8'h00, 8'h00, 32'h0, 32'h0, 8'hd7, 8'h1f, 8'hd7, 8'hd7);
    t(8'h00, 8'h00, 32'h0, 32'h0, 8'hd7, flag_pkg::OP_NMIRET, 8'hd7, 8'hd7);
    chk({31'h0, irq_enable}, 32'h1, 32'h1);
    t(8'h10, 8'h01, 32'h0, 32'h0, 8'h01, flag_pkg::OP_SBC, 8'h12, 8'hd7);
    t(8'h00, 8'hff, 32'h0, 32'h0, 8'h01, flag_pkg::OP_INC, 8'h51, 8'hd7);
    t(8'h00, 8'h80, 32'h0, 32'h0, 8'h00, flag_pkg::OP_DEC, 8'h16, 8'hd7);
    t(8'h12, 8'h34, 32'h0, 32'h0, 8'h00, flag_pkg::OP_DIG_R, 8'h04, 8'hd7);
    t(8'h81, 8'h00, 32'h0, 32'h0, 8'hd6, {3'h0, flag_pkg::OP_ROT_A}, 8'hc5, 8'hd7);
    t(8'h00, 8'h01, 32'h0, 32'h0, 8'h01, {3'h3, flag_pkg::OP_SHIFT}, 8'h81, 8'hd7);
    t(8'h00, 8'h81, 32'h0, 32'h0, 8'h00, {3'h5, flag_pkg::OP_SHIFT}, 8'h85, 8'hd7);
    t(8'h00, 8'h00, 32'h0, 32'h0, 8'h00, flag_pkg::OP_CPL, 8'h12, 8'hd7);
    t(8'h00, 8'h00, 32'h0, 32'h0, 8'h01, flag_pkg::OP_CCF, 8'h00, 8'hc7);
    bcd(8'h15, 8'h27, flag_pkg::OP_ADD, 8'h42, 8'h04);
    bcd(8'h42, 8'h15, flag_pkg::OP_SUB, 8'h27, 8'h06);
    end_sim();
  end
endmodule
